// ===== pkg/rftor_consts.svh
// Purpose: Offsets, field positions and reset values of the radio test override bank.
// Assumes: 8-bit register port, one register per address.
// Notes:   Definitions only.
`ifndef RFTOR_CONSTS_SVH
`define RFTOR_CONSTS_SVH

// Register addresses.
`define RFTOR_A_TRIM    8'h1f
`define RFTOR_A_SLEEP   8'h20
`define RFTOR_A_SYN_A   8'h21
`define RFTOR_A_SYN_B   8'h22
`define RFTOR_A_OSC     8'h23
`define RFTOR_A_PUMP    8'h24
`define RFTOR_A_CONV    8'h25
`define RFTOR_A_GAIN    8'h26

// Reset values, and the write mask of gain_stage_override.
`define RFTOR_R_TRIM    8'h00
`define RFTOR_R_SLEEP   8'h00
`define RFTOR_R_SYN_A   8'h4d
`define RFTOR_R_SYN_B   8'h10
`define RFTOR_R_OSC     8'h06
`define RFTOR_R_PUMP    8'h00
`define RFTOR_R_CONV    8'h40
`define RFTOR_R_GAIN    8'h00
`define RFTOR_M_GAIN    8'h0f

// Sleep mode value that lets the sleep bits act.
`define RFTOR_SLEEP_MODE_BITS 2'h2

// Field positions, synth_override_a.
`define RFTOR_F_DAC_HI  7
`define RFTOR_F_DAC_LO  4
`define RFTOR_F_CHP_HI  3
`define RFTOR_F_CHP_LO  0
// synth_override_b.
`define RFTOR_F_LOOP    7
`define RFTOR_F_CHP_SEL 6
`define RFTOR_F_ARR_SEL 5
`define RFTOR_F_ARR_HI  4
`define RFTOR_F_ARR_LO  0
// osc_current_override.
`define RFTOR_F_HAND    7
`define RFTOR_F_CUR_SEL 6
`define RFTOR_F_CUR_HI  5
`define RFTOR_F_CUR_LO  0
// pump_mixer_test_ctrl.
`define RFTOR_F_P_OFF   7
`define RFTOR_F_P_UP    6
`define RFTOR_F_P_DN    5
`define RFTOR_F_IQ_HI   4
`define RFTOR_F_IQ_LO   3
`define RFTOR_F_DC_ON   2
`define RFTOR_F_FLT     1
`define RFTOR_F_CNV     0
// converter_test_ctrl.
`define RFTOR_F_FCOMP   7
`define RFTOR_F_JITTER  6
`define RFTOR_F_TOUT    5
`define RFTOR_F_CHOP    4
`define RFTOR_F_SHAPE   3
`define RFTOR_F_VCM     2
`define RFTOR_F_ROT_HI  1
`define RFTOR_F_ROT_LO  0
// gain_stage_override.
`define RFTOR_F_G_OVR   3
`define RFTOR_F_AC1     2
`define RFTOR_F_AC2_HI  1
`define RFTOR_F_AC2_LO  0

`endif

// ===== pkg/rftor_pkg.sv
// Purpose: Types of the radio test override bank.
// Assumes: Constants come from rftor_consts.svh.
// Notes:   Structs carry grouped signals and whole module state.
package rftor_pkg;

    // Synthesizer settings, calibrated or applied.
    typedef struct packed {
        logic [3:0] dac;
        logic [3:0] pump;
        logic [4:0] array;
        logic [5:0] current;
    } rftor_synth_t;

    // Levels for the three shared digital pins.
    typedef struct packed {
        logic lock;
        logic serial_bitstream_pin;
        logic bit_timing_pin;
    } rftor_pins_t;

    typedef struct packed {
        logic [1:0] phase;
        logic [1:0] position;
    } rftor_rot_state_t;

    typedef struct packed {
        logic [7:0]   trim;
        logic [7:0]   sleep;
        logic [7:0]   syn_a;
        logic [7:0]   syn_b;
        logic [7:0]   osc;
        logic [7:0]   pump;
        logic [7:0]   conv;
        logic [7:0]   gain;
        logic [7:0]   rdata;
        logic [7:0]   sleep_out;
        rftor_synth_t applied;
        logic         loop_open;
        logic         strobe;
        logic         cal_sample;
        logic [2:0]   pump_test;
        logic [2:0]   mixer_test;
        logic [1:0]   connect;
        logic         probe_sleep;
        logic [2:0]   probe_mode;
        rftor_pins_t  pins;
        logic [4:0]   conv_flags;
        logic         ac1;
        logic [1:0]   ac2;
    } rftor_state_t;

endpackage : rftor_pkg

// ===== rtl/rftor_rotator.sv
// Purpose: Converter input rotation sequencer.
// Assumes: step is a one-cycle pulse per converter clock.
// Notes:   Position comes straight from a flip-flop.
`include "rftor_consts.svh"

module rftor_rotator (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       arst_n,
    input  wire logic       clk_en,
    // Control
    input  wire logic       step,
    input  wire logic [1:0] code,
    // Result
    output logic      [1:0] position
);

    rftor_pkg::rftor_rot_state_t st_reg;
    rftor_pkg::rftor_rot_state_t st_next;

    // Code 2 parks at 00; the phase still runs so a later code change starts cleanly.
    function automatic logic [1:0] pick(input logic [1:0] c, input logic [1:0] ph);
        logic [1:0] r;
        r = 2'h0;
        case (c)
            2'h0: r = ph;
            2'h1: r = (ph == 2'h0) ? 2'h0 : (ph == 2'h1) ? 2'h2 : (ph == 2'h2) ? 2'h3 : 2'h1;
            2'h2: r = 2'h0;
            default: r = ph[0] ? 2'h2 : 2'h0;
        endcase
        return r;
    endfunction : pick

    always_comb begin
        st_next = st_reg;
        if (step) begin
            st_next.phase    = st_reg.phase + 2'h1;
            st_next.position = pick(code, st_reg.phase + 2'h1);
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= '0;
        end else if (clk_en) begin
            st_reg <= st_next;
        end
    end

    assign position = st_reg.position;

endmodule : rftor_rotator

// ===== rtl/rftor_regs.sv
// Purpose: Test override and power-down register bank of a narrowband radio.
// Assumes: Single clock; register port answers reads one cycle later, never stalls.
// Notes:   All outputs but gain_trim lag the registers by one cycle; gain_trim is the trim register itself.
//
// Decided for this implementation: strobed register access.
`include "rftor_consts.svh"

// How it works
// - Hold signed 8-bit mixer gain trim word, reset zero.
// - Eight sleep bits force blocks off only when sleep mode equals 2.
// - Loop-break bit opens loop; calibration DAC takes override field, reset 4.
// - Pump current uses override field (reset 13) when its select bit set.
// - Oscillator array uses override field (reset 16) when select bit set.
// - Oscillator current uses override field (reset 6) when select bit set and hand mode off.
// - In hand mode the select bit is the cal strobe; falling edge samples comparator.
// - Pump disable, force-up and force-down bits pass to the pump, reset zero.
// - Mixer DC test sets I and Q polarity from 2-bit field.
// - Connect bits attach probe module to filter or converter inputs.
// - With a connect bit, interface nibble drives probe; else sleep and mode2 high.
// - Converter test output drives samples on lock/data pins, clock on timing pin.
// - Rotation field picks converter input rotation order, reset zero.
// - Dither bit enables modulator clock jitter, reset one.
// - Comparator enable brings frequency comparator output out, reset zero.
// - Three bits disable chopping, feedback shaping and common-mode rotation.
// - Gain override forces first coupler from its bit, reset zero.
// - Gain override forces second coupler from 2-bit field, reset zero.
module rftor_regs (
    // Clock and reset
    input  wire logic                       clk_sys,
    input  wire logic                       arst_n,
    input  wire logic                       clk_en,
    // Register port
    input  wire logic [7:0]                 reg_addr,
    input  wire logic [7:0]                 reg_wdata,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    output logic      [7:0]                 reg_rdata,
    // Inputs from the rest of the radio
    input  wire logic [1:0]                 sleep_mode_select,
    input  wire logic [3:0]                 probe_iface,
    input  wire rftor_pkg::rftor_synth_t    synth_cal,
    input  wire logic                       osc_cal_comparator,
    input  wire rftor_pkg::rftor_pins_t     pins_normal,
    input  wire logic [1:0]                 conv_sample,
    input  wire logic                       conv_clk_level,
    input  wire logic                       conv_clk_tick,
    input  wire logic                       freq_comp_in,
    input  wire logic                       ac1_auto,
    input  wire logic [1:0]                 ac2_auto,
    // Applied settings
    output logic      [7:0]                 gain_trim,
    output logic      [7:0]                 block_sleep,
    output rftor_pkg::rftor_synth_t         synth_applied,
    output logic                            loop_open,
    output logic                            osc_cal_strobe,
    output logic                            osc_cal_sample,
    output logic                            pump_normal_off,
    output logic                            pump_force_up,
    output logic                            pump_force_down,
    output logic                            mixer_dc_test_on,
    output logic                            mixer_i_pos,
    output logic                            mixer_q_pos,
    output logic                            filter_test_connect,
    output logic                            converter_test_connect,
    output logic                            analog_probe_sleep,
    output logic      [2:0]                 probe_mode,
    output rftor_pkg::rftor_pins_t          pins_out,
    output logic      [1:0]                 rot_position,
    output logic                            modulator_clock_jitter_on,
    output logic                            freq_comp_out,
    output logic                            integrator_chopping_off,
    output logic                            feedback_shaping_off,
    output logic                            common_mode_rotation_off,
    output logic                            first_coupler_gain,
    output logic      [1:0]                 second_coupler_gain
);

    rftor_pkg::rftor_state_t st_reg;
    rftor_pkg::rftor_state_t st_next;
    logic                    wr_hit;
    logic                    any_connect;
    logic                    hand;

    assign any_connect = st_reg.pump[`RFTOR_F_FLT] | st_reg.pump[`RFTOR_F_CNV];
    assign hand        = st_reg.osc[`RFTOR_F_HAND];

    always_comb begin
        st_next = st_reg;
        wr_hit  = reg_wr;

        // Register writes.
        if (wr_hit) begin
            if (reg_addr == `RFTOR_A_TRIM) begin
                st_next.trim = reg_wdata;
            end else if (reg_addr == `RFTOR_A_SLEEP) begin
                st_next.sleep = reg_wdata;
            end else if (reg_addr == `RFTOR_A_SYN_A) begin
                st_next.syn_a = reg_wdata;
            end else if (reg_addr == `RFTOR_A_SYN_B) begin
                st_next.syn_b = reg_wdata;
            end else if (reg_addr == `RFTOR_A_OSC) begin
                st_next.osc = reg_wdata;
            end else if (reg_addr == `RFTOR_A_PUMP) begin
                st_next.pump = reg_wdata;
            end else if (reg_addr == `RFTOR_A_CONV) begin
                st_next.conv = reg_wdata;
            end else if (reg_addr == `RFTOR_A_GAIN) begin
                st_next.gain = reg_wdata & `RFTOR_M_GAIN;
            end
        end

        // Read data stand for one cycle only; unmapped addresses answer zero.
        st_next.rdata = 8'h00;
        if (reg_rd) begin
            if (reg_addr == `RFTOR_A_TRIM) begin
                st_next.rdata = st_reg.trim;
            end else if (reg_addr == `RFTOR_A_SLEEP) begin
                st_next.rdata = st_reg.sleep;
            end else if (reg_addr == `RFTOR_A_SYN_A) begin
                st_next.rdata = st_reg.syn_a;
            end else if (reg_addr == `RFTOR_A_SYN_B) begin
                st_next.rdata = st_reg.syn_b;
            end else if (reg_addr == `RFTOR_A_OSC) begin
                st_next.rdata = st_reg.osc;
            end else if (reg_addr == `RFTOR_A_PUMP) begin
                st_next.rdata = st_reg.pump;
            end else if (reg_addr == `RFTOR_A_CONV) begin
                st_next.rdata = st_reg.conv;
            end else if (reg_addr == `RFTOR_A_GAIN) begin
                st_next.rdata = st_reg.gain;
            end
        end

        // Sleep bits only take effect in the dedicated sleep mode.
        st_next.sleep_out = (sleep_mode_select == `RFTOR_SLEEP_MODE_BITS) ?
                            st_reg.sleep : 8'h00;

        // Synthesizer overrides.
        st_next.loop_open   = st_reg.syn_b[`RFTOR_F_LOOP];
        st_next.applied.dac = st_reg.syn_b[`RFTOR_F_LOOP] ?
                              st_reg.syn_a[`RFTOR_F_DAC_HI:`RFTOR_F_DAC_LO] :
                              synth_cal.dac;
        st_next.applied.pump = st_reg.syn_b[`RFTOR_F_CHP_SEL] ?
                               st_reg.syn_a[`RFTOR_F_CHP_HI:`RFTOR_F_CHP_LO] :
                               synth_cal.pump;
        st_next.applied.array = st_reg.syn_b[`RFTOR_F_ARR_SEL] ?
                                st_reg.syn_b[`RFTOR_F_ARR_HI:`RFTOR_F_ARR_LO] :
                                synth_cal.array;
        // In hand mode the select bit is a strobe, so it must not also force the current.
        st_next.applied.current = (st_reg.osc[`RFTOR_F_CUR_SEL] && !hand) ?
                                  st_reg.osc[`RFTOR_F_CUR_HI:`RFTOR_F_CUR_LO] :
                                  synth_cal.current;

        // Hand calibration: strobe follows the select bit, its falling edge samples.
        st_next.strobe = hand & st_reg.osc[`RFTOR_F_CUR_SEL];
        if (st_reg.strobe && !st_next.strobe) begin
            st_next.cal_sample = osc_cal_comparator;
        end

        // Pump and mixer tests.
        st_next.pump_test = st_reg.pump[`RFTOR_F_P_OFF:`RFTOR_F_P_DN];
        st_next.mixer_test[2] = st_reg.pump[`RFTOR_F_DC_ON];
        st_next.mixer_test[1:0] = st_reg.pump[`RFTOR_F_DC_ON] ?
                                  st_reg.pump[`RFTOR_F_IQ_HI:`RFTOR_F_IQ_LO] : 2'h0;

        // Probe routing.
        st_next.connect = st_reg.pump[`RFTOR_F_FLT:`RFTOR_F_CNV];
        if (any_connect) begin
            st_next.probe_sleep = probe_iface[3];
            st_next.probe_mode  = probe_iface[2:0];
        end else begin
            st_next.probe_sleep = 1'b1;
            st_next.probe_mode  = {1'b1, probe_iface[1:0]};
        end

        // Converter test output takes over the shared pins.
        if (st_reg.conv[`RFTOR_F_TOUT]) begin
            st_next.pins.lock = conv_sample[1];
            st_next.pins.serial_bitstream_pin  = conv_sample[0];
            st_next.pins.bit_timing_pin = conv_clk_level;
        end else begin
            st_next.pins = pins_normal;
        end

        // Converter options: jitter, comparator, chop, shape, common-mode rotation.
        st_next.conv_flags[4] = st_reg.conv[`RFTOR_F_JITTER];
        st_next.conv_flags[3] = st_reg.conv[`RFTOR_F_FCOMP] & freq_comp_in;
        st_next.conv_flags[2:0] = st_reg.conv[`RFTOR_F_CHOP:`RFTOR_F_VCM];

        // Coupler overrides.
        st_next.ac1 = st_reg.gain[`RFTOR_F_G_OVR] ? st_reg.gain[`RFTOR_F_AC1] : ac1_auto;
        st_next.ac2 = st_reg.gain[`RFTOR_F_G_OVR] ?
                      st_reg.gain[`RFTOR_F_AC2_HI:`RFTOR_F_AC2_LO] : ac2_auto;
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st_reg       <= '0;
            st_reg.trim  <= `RFTOR_R_TRIM;
            st_reg.sleep <= `RFTOR_R_SLEEP;
            st_reg.syn_a <= `RFTOR_R_SYN_A;
            st_reg.syn_b <= `RFTOR_R_SYN_B;
            st_reg.osc   <= `RFTOR_R_OSC;
            st_reg.pump  <= `RFTOR_R_PUMP;
            st_reg.conv  <= `RFTOR_R_CONV;
            st_reg.gain  <= `RFTOR_R_GAIN;
            st_reg.probe_sleep <= 1'b1;
            st_reg.probe_mode  <= 3'h4;
        end else if (clk_en) begin
            st_reg <= st_next;
        end
    end

    rftor_rotator u_rot (
        .clk_sys  (clk_sys),
        .arst_n   (arst_n),
        .clk_en   (clk_en),
        .step     (conv_clk_tick),
        .code     (st_reg.conv[`RFTOR_F_ROT_HI:`RFTOR_F_ROT_LO]),
        .position (rot_position)
    );

    assign reg_rdata                 = st_reg.rdata;
    assign gain_trim                 = st_reg.trim;
    assign block_sleep               = st_reg.sleep_out;
    assign synth_applied             = st_reg.applied;
    assign loop_open                 = st_reg.loop_open;
    assign osc_cal_strobe            = st_reg.strobe;
    assign osc_cal_sample            = st_reg.cal_sample;
    assign pump_normal_off           = st_reg.pump_test[2];
    assign pump_force_up             = st_reg.pump_test[1];
    assign pump_force_down           = st_reg.pump_test[0];
    assign mixer_dc_test_on          = st_reg.mixer_test[2];
    assign mixer_i_pos               = st_reg.mixer_test[1];
    assign mixer_q_pos               = st_reg.mixer_test[0];
    assign filter_test_connect       = st_reg.connect[1];
    assign converter_test_connect    = st_reg.connect[0];
    assign analog_probe_sleep        = st_reg.probe_sleep;
    assign probe_mode                = st_reg.probe_mode;
    assign pins_out                  = st_reg.pins;
    assign modulator_clock_jitter_on = st_reg.conv_flags[4];
    assign freq_comp_out             = st_reg.conv_flags[3];
    assign integrator_chopping_off   = st_reg.conv_flags[2];
    assign feedback_shaping_off      = st_reg.conv_flags[1];
    assign common_mode_rotation_off  = st_reg.conv_flags[0];
    assign first_coupler_gain        = st_reg.ac1;
    assign second_coupler_gain       = st_reg.ac2;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    sequence s_trim_wr;
        clk_en && reg_wr && reg_addr == `RFTOR_A_TRIM;
    endsequence
    sequence s_trim_rd;
        clk_en && reg_rd && !reg_wr && reg_addr == `RFTOR_A_TRIM;
    endsequence

    property p_trim;
        logic [7:0] d;
        (s_trim_wr, d = reg_wdata) |=> gain_trim == d;
    endproperty
    a_trim: assert property (p_trim) else $error("trim write lost");

    property p_sleep;
        clk_en |=> block_sleep == (($past(sleep_mode_select) == 2'h2) ? $past(st_reg.sleep) : 8'h00);
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep gating wrong");

    property p_loop;
        clk_en && st_reg.syn_b[7] |=> loop_open && synth_applied.dac == $past(st_reg.syn_a[7:4]);
    endproperty
    a_loop: assert property (p_loop) else $error("open loop dac wrong");

    property p_pump;
        clk_en |=> synth_applied.pump ==
                   ($past(st_reg.syn_b[6]) ? $past(st_reg.syn_a[3:0]) : $past(synth_cal.pump));
    endproperty
    a_pump: assert property (p_pump) else $error("pump current select wrong");

    property p_array;
        clk_en && !st_reg.syn_b[5] |=> synth_applied.array == $past(synth_cal.array);
    endproperty
    a_array: assert property (p_array) else $error("array select wrong");

    property p_strobe;
        clk_en && osc_cal_strobe && !(hand && st_reg.osc[6]) |=>
            osc_cal_sample == $past(osc_cal_comparator) && !osc_cal_strobe;
    endproperty
    a_strobe: assert property (p_strobe) else $error("strobe sample missed");

    property p_mixer;
        clk_en && st_reg.pump[2] |=> {mixer_i_pos, mixer_q_pos} == $past(st_reg.pump[4:3]);
    endproperty
    a_mixer: assert property (p_mixer) else $error("mixer polarity wrong");

    property p_probe;
        clk_en && !any_connect |=> analog_probe_sleep && probe_mode[2];
    endproperty
    a_probe: assert property (p_probe) else $error("probe not parked");

    property p_rdata;
        logic [7:0] d;
        (s_trim_rd, d = st_reg.trim) ##1 (clk_en && !reg_rd) |-> reg_rdata == d ##1 reg_rdata == 8'h00;
    endproperty
    a_rdata: assert property (p_rdata) else $error("read data wrong");

endmodule : rftor_regs

// ===== tb/rftor_regs_test.sv
// Purpose: Self-checking bench of the radio test override bank.
// Assumes: Reads answer one cycle late; derived outputs follow a write two edges later.
// Notes:   Seeded random registers and inputs, plus all-ones, all-zero and hand corners.
`include "rftor_consts.svh"

module rftor_regs_test;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_sys, arst_n, clk_en, reg_wr, reg_rd, osc_cal_comparator;
    logic conv_clk_level, conv_clk_tick, freq_comp_in, ac1_auto;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, gain_trim, block_sleep, seen, v;
    logic [3:0] probe_iface;
    logic [2:0] probe_mode;
    logic [1:0] sleep_mode_select, conv_sample, ac2_auto, rot_position, second_coupler_gain;
    logic [1:0] p, q;
    rftor_pkg::rftor_synth_t synth_cal, synth_applied, s;
    rftor_pkg::rftor_pins_t  pins_normal, pins_out;
    logic loop_open, osc_cal_strobe, osc_cal_sample, pump_normal_off, pump_force_up;
    logic pump_force_down, mixer_dc_test_on, mixer_i_pos, mixer_q_pos, filter_test_connect;
    logic converter_test_connect, analog_probe_sleep, modulator_clock_jitter_on;
    logic freq_comp_out, integrator_chopping_off, feedback_shaping_off;
    logic common_mode_rotation_off, first_coupler_gain;
    logic [31:0] r;
    logic [7:0] rv [8];
    localparam logic [7:0] RST [8] = '{`RFTOR_R_TRIM, `RFTOR_R_SLEEP, `RFTOR_R_SYN_A,
        `RFTOR_R_SYN_B, `RFTOR_R_OSC, `RFTOR_R_PUMP, `RFTOR_R_CONV, `RFTOR_R_GAIN};
    int errors = 0;
    int comparisons = 0;
    int cycles = 0;

    rftor_regs dut (.clk_sys, .arst_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .sleep_mode_select, .probe_iface, .synth_cal, .osc_cal_comparator,
        .pins_normal, .conv_sample, .conv_clk_level, .conv_clk_tick, .freq_comp_in,
        .ac1_auto, .ac2_auto, .gain_trim, .block_sleep, .synth_applied, .loop_open,
        .osc_cal_strobe, .osc_cal_sample, .pump_normal_off, .pump_force_up, .pump_force_down,
        .mixer_dc_test_on, .mixer_i_pos, .mixer_q_pos, .filter_test_connect,
        .converter_test_connect, .analog_probe_sleep, .probe_mode, .pins_out, .rot_position,
        .modulator_clock_jitter_on, .freq_comp_out, .integrator_chopping_off,
        .feedback_shaping_off, .common_mode_rotation_off, .first_coupler_gain,
        .second_coupler_gain);

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    // A hung handshake would otherwise stall the run forever.
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            conclude();
        end
    end

    task automatic conclude();
        if (errors == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : conclude

    task automatic chk(input string name, input logic [31:0] sv, input logic [31:0] ev);
        comparisons++;
        if (sv !== ev) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", name, ev, sv);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd

    task automatic settle();
        repeat (2) @(posedge clk_sys);
        #1;
    endtask : settle

    task automatic tick(output logic [1:0] pos);
        @(posedge clk_sys);
        conv_clk_tick <= 1'b1;
        @(posedge clk_sys);
        conv_clk_tick <= 1'b0;
        @(posedge clk_sys);
        #1 pos = rot_position;
    endtask : tick

    function automatic logic [1:0] succ(input logic [1:0] code, input logic [1:0] pv);
        case (code)
            2'h0: succ = pv + 2'h1;
            2'h1: succ = pv == 2'h0 ? 2'h2 : pv == 2'h2 ? 2'h3 : pv == 2'h3 ? 2'h1 : 2'h0;
            2'h2: succ = 2'h0;
            default: succ = pv ^ 2'h2;
        endcase
    endfunction : succ

    task automatic check_all();
        s.dac = rv[3][7] ? rv[2][7:4] : synth_cal.dac;
        s.pump = rv[3][6] ? rv[2][3:0] : synth_cal.pump;
        s.array = rv[3][5] ? rv[3][4:0] : synth_cal.array;
        s.current = (rv[4][6] && !rv[4][7]) ? rv[4][5:0] : synth_cal.current;
        chk("gain_trim", gain_trim, rv[0]);
        chk("block_sleep", block_sleep, sleep_mode_select == 2'h2 ? rv[1] : 8'h00);
        chk("synth_applied", synth_applied, s);
        chk("loop_open", loop_open, rv[3][7]);
        chk("osc_cal_strobe", osc_cal_strobe, rv[4][7] & rv[4][6]);
        chk("pump_test", {pump_normal_off, pump_force_up, pump_force_down}, rv[5][7:5]);
        chk("mixer", {mixer_dc_test_on, mixer_i_pos, mixer_q_pos},
            {rv[5][2], rv[5][2] & rv[5][4], rv[5][2] & rv[5][3]});
        chk("connect", {filter_test_connect, converter_test_connect}, rv[5][1:0]);
        chk("probe", {analog_probe_sleep, probe_mode},
            |rv[5][1:0] ? probe_iface : {2'b11, probe_iface[1:0]});
        chk("pins_out", pins_out, rv[6][5] ? {conv_sample, conv_clk_level} : pins_normal);
        chk("conv_flags", {modulator_clock_jitter_on, freq_comp_out, integrator_chopping_off,
            feedback_shaping_off, common_mode_rotation_off},
            {rv[6][6], rv[6][7] & freq_comp_in, rv[6][4:2]});
        chk("couplers", {first_coupler_gain, second_coupler_gain},
            rv[7][3] ? rv[7][2:0] : {ac1_auto, ac2_auto});
        for (int i = 0; i < 8; i++) begin
            rd(8'(8'h1f + i), seen);
            chk("readback", seen, rv[i]);
        end
    endtask : check_all

    initial begin
        {arst_n, reg_wr, reg_rd, reg_addr, reg_wdata, sleep_mode_select, probe_iface} = '0;
        {synth_cal, pins_normal, conv_sample, conv_clk_level, conv_clk_tick} = '0;
        {osc_cal_comparator, freq_comp_in, ac1_auto, ac2_auto} = '0;
        clk_en = 1'b1;
        r = $urandom(50);
        repeat (2) @(posedge clk_sys);
        arst_n <= 1'b1;
        rv = RST;
        settle();
        check_all();
        wr(8'h27, 8'hff);
        rd(8'h27, seen);
        chk("unmapped", seen, 8'h00);
        @(posedge clk_sys);
        clk_en <= 1'b0;
        wr(`RFTOR_A_TRIM, 8'h5a);
        @(posedge clk_sys);
        clk_en <= 1'b1;
        settle();
        chk("frozen_trim", gain_trim, rv[0]);
        for (int n = 0; n < 24; n++) begin
            r = $urandom;
            @(posedge clk_sys);
            sleep_mode_select <= n[1:0];
            probe_iface <= r[3:0];
            {synth_cal, pins_normal, conv_sample, conv_clk_level} <= r[31:7];
            {freq_comp_in, ac1_auto, ac2_auto} <= r[6:3];
            for (int i = 0; i < 8; i++) begin
                v = n == 0 ? 8'hff : n == 1 ? 8'h00 : 8'($urandom);
                // Hand calibration mode gets its own scenario below.
                v[7] = i == 4 ? 1'b0 : v[7];
                wr(8'(8'h1f + i), v);
                rv[i] = i == 7 ? v & `RFTOR_M_GAIN : v;
            end
            settle();
            check_all();
        end
        for (int k = 0; k < 2; k++) begin
            @(posedge clk_sys);
            osc_cal_comparator <= k[0];
            wr(`RFTOR_A_OSC, 8'hc5);
            settle();
            chk("strobe_high", osc_cal_strobe, 1'b1);
            chk("hand_current", synth_applied.current, synth_cal.current);
            wr(`RFTOR_A_OSC, 8'h85);
            settle();
            chk("strobe_low", osc_cal_strobe, 1'b0);
            chk("cal_sample", osc_cal_sample, k[0]);
        end
        for (int c = 0; c < 4; c++) begin
            wr(`RFTOR_A_CONV, 8'h40 | 8'(c));
            settle();
            tick(p);
            for (int t = 0; t < 5; t++) begin
                tick(q);
                chk("rot_position", q, succ(c[1:0], p));
                p = q;
            end
        end
        @(posedge clk_sys);
        arst_n <= 1'b0;
        @(posedge clk_sys);
        arst_n <= 1'b1;
        rv = RST;
        settle();
        check_all();
        conclude();
    end

endmodule : rftor_regs_test
